// File: inc/fled_pkg.sv
package fled_pkg;
  // register map
  localparam logic [7:0] ADDR_MODE  = 8'h01;
  localparam logic [7:0] ADDR_CFG   = 8'h02;
  localparam logic [7:0] ADDR_FLASH = 8'h03;
  localparam logic [7:0] ADDR_TORCH = 8'h04;
  localparam logic [7:0] ADDR_FAULT = 8'h05;
  localparam logic [7:0] ADDR_ID    = 8'h06;
  // reset values
  localparam logic [7:0] MODE_RST  = 8'h20;
  localparam logic [7:0] CFG_RST   = 8'h19;
  localparam logic [6:0] FLASH_RST = 7'h00;
  localparam logic [6:0] TORCH_RST = 7'h00;
  localparam logic [7:0] FAULT_RST = 8'h00;
  // field positions
  localparam int MODE_PIN_EN_BIT = 2;
  localparam int MODE_EDGE_BIT   = 3;
  localparam int MODE_GUARD_BIT  = 4;
  localparam int CFG_RAMP_BIT    = 0;
  localparam int CFG_TO_LSB      = 1;
  localparam int CFG_THR_LSB     = 5;
  localparam int FLT_GUARD_BIT   = 6;
  localparam int FLT_SHORT_BIT   = 5;
  localparam int FLT_TSD_BIT     = 2;
  localparam int FLT_UVL_BIT     = 1;
  localparam int FLT_TO_BIT      = 0;
  localparam int ID_SWRST_BIT    = 7;
  // i2c
  localparam logic [6:0] I2C_DEV_ADDR = 7'h64;
  localparam logic [3:0] BYTE_BITS    = 4'h8;
  // flash time-out table, in ms
  localparam logic [10:0] TO_STEP_MS      = 11'h028;
  localparam logic [3:0]  TO_SHORT_MAX    = 4'h9;
  localparam logic [10:0] TO_UNDEF_MS     = 11'h190;
  localparam logic [3:0]  TO_800_CODE     = 4'hb;
  localparam logic [10:0] TO_800_MS       = 11'h320;
  localparam logic [3:0]  TO_1000_CODE    = 4'hc;
  localparam logic [10:0] TO_1000_MS      = 11'h3e8;
  localparam logic [3:0]  TO_LONG_CODE    = 4'hd;
  localparam logic [10:0] TO_LONG_MS      = 11'h4b0;
  localparam logic [10:0] TO_LONG_STEP_MS = 11'h0c8;
  // timing
  localparam int unsigned CLK_FREQ_KHZ    = 25000;
  localparam int unsigned CYC_PER_MS_DFLT = CLK_FREQ_KHZ * 1;
  localparam int unsigned RAMP_TIME_MS    = 1;
  localparam int unsigned RAMP_STEPS      = 128;

  typedef enum logic [1:0] {
    MODE_STANDBY = 2'h0,
    MODE_IR      = 2'h1,
    MODE_TORCH   = 2'h2,
    MODE_FLASH   = 2'h3
  } fled_mode_e;

  typedef enum logic [3:0] {
    I2C_IDLE, I2C_ADDR, I2C_AACK, I2C_REG, I2C_RACK,
    I2C_WR, I2C_WACK, I2C_RD, I2C_MACK
  } fled_i2c_e;
endpackage

// File: inc/fled_reg_if.sv
interface fled_reg_if;
  logic [7:0] regAddr;
  logic       wrStb;
  logic [7:0] wrData;
  logic [7:0] rdData;
  modport target (output regAddr, output wrStb, output wrData,
                  input rdData);
  modport bank (input regAddr, input wrStb, input wrData,
                output rdData);
endinterface

// File: logic/fled_i2c_target.sv
module fled_i2c_target
  import fled_pkg::*;
(
  input  wire logic  clk_sys,
  input  wire logic  rst,
  input  wire logic  scl,
  input  wire logic  sdaIn,
  output logic       sdaOeN,
  fled_reg_if.target bus
);
  typedef struct packed {
    fled_i2c_e  st;
    logic [2:0] sclS;
    logic [2:0] sdaS;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic       rw;
    logic       mAck;
    logic [7:0] ptr;
    logic       oeN;
    logic       wr;
  } fled_i2c_s;

  fled_i2c_s q;
  fled_i2c_s d;
  logic      sclR;
  logic      sclF;
  logic      sdaV;
  logic      start;
  logic      stop;
  logic      byteDone;

  // stage 0 of each synchroniser feeds only stage 1
  assign sdaV     = q.sdaS[1];
  assign sclR     = q.sclS[1] & ~q.sclS[2];
  assign sclF     = ~q.sclS[1] & q.sclS[2];
  assign start    = q.sclS[1] & q.sclS[2] & q.sdaS[2] & ~sdaV;
  assign stop     = q.sclS[1] & q.sclS[2] & ~q.sdaS[2] & sdaV;
  assign byteDone = sclF && q.cnt == BYTE_BITS;

  always_comb begin
    d      = q;
    d.sclS = {q.sclS[1:0], scl};
    d.sdaS = {q.sdaS[1:0], sdaIn};
    d.wr   = 1'b0;
    if (start) begin
      d.st  = I2C_ADDR;
      d.cnt = 4'h0;
      d.oeN = 1'b1;
    end else if (stop) begin
      d.st  = I2C_IDLE;
      d.oeN = 1'b1;
    end else begin
      if (sclR && q.st inside {I2C_ADDR, I2C_REG, I2C_WR}) begin
        d.sh  = {q.sh[6:0], sdaV};
        d.cnt = q.cnt + 4'h1;
      end
      unique case (q.st)
        I2C_IDLE: ;
        I2C_ADDR: if (byteDone) begin
          if (q.sh[7:1] == I2C_DEV_ADDR) begin
            d.rw  = q.sh[0];
            d.oeN = 1'b0;
            d.st  = I2C_AACK;
          end else begin
            d.st = I2C_IDLE;
          end
        end
        I2C_AACK: if (sclF) begin
          d.cnt = 4'h0;
          if (q.rw) begin
            d.sh  = bus.rdData;
            d.oeN = bus.rdData[7];
            d.st  = I2C_RD;
          end else begin
            d.oeN = 1'b1;
            d.st  = I2C_REG;
          end
        end
        I2C_REG: if (byteDone) begin
          d.ptr = q.sh;
          d.oeN = 1'b0;
          d.st  = I2C_RACK;
        end
        I2C_RACK: if (sclF) begin
          d.oeN = 1'b1;
          d.cnt = 4'h0;
          d.st  = I2C_WR;
        end
        I2C_WR: if (byteDone) begin
          d.wr  = 1'b1;
          d.oeN = 1'b0;
          d.st  = I2C_WACK;
        end
        I2C_WACK: if (sclF) begin
          d.oeN = 1'b1;
          d.cnt = 4'h0;
          d.ptr = q.ptr + 8'h01; // RL14
          d.st  = I2C_WR;
        end
        I2C_RD: if (sclR) begin
          d.cnt = q.cnt + 4'h1;
        end else if (sclF) begin
          if (q.cnt == BYTE_BITS) begin
            d.oeN = 1'b1;
            d.st  = I2C_MACK;
          end else begin
            d.sh  = {q.sh[6:0], 1'b0};
            d.oeN = q.sh[6];
          end
        end
        // pointer moves on the master's ack so the next byte is ready
        I2C_MACK: if (sclR) begin
          d.mAck = ~sdaV;
          if (!sdaV) d.ptr = q.ptr + 8'h01; // RL14
        end else if (sclF) begin
          if (q.mAck) begin
            d.sh  = bus.rdData;
            d.oeN = bus.rdData[7];
            d.cnt = 4'h0;
            d.st  = I2C_RD;
          end else begin
            d.st = I2C_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= '{st: I2C_IDLE, sclS: 3'h7, sdaS: 3'h7, sh: 8'h00,
             cnt: 4'h0, rw: 1'b0, mAck: 1'b0, ptr: 8'h00,
             oeN: 1'b1, wr: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign sdaOeN      = q.oeN;
  assign bus.regAddr = q.ptr;
  assign bus.wrStb   = q.wr;
  assign bus.wrData  = q.sh;

  property p_autoinc;
    @(posedge clk_sys) disable iff (rst)
    q.st == I2C_WACK && sclF && !start && !stop
      |=> q.ptr == $past(q.ptr) + 8'h01 ##1 !q.wr;
  endproperty
  a_autoinc: assert property (p_autoinc) // RL14
    else $error("pointer not advanced after write ack");

  c_wr_burst: cover property (@(posedge clk_sys) disable iff (rst)
    q.wr ##[1:1000] q.wr);
endmodule

// File: logic/fled_driver_regs.sv
// Summary of operation
// RL1 - reserved bits are dropped on write and read back fixed
// RL2 - mode bits: mode, trigger pin enable, level or edge, guard enable
// RL3 - a trigger pulse of any width turns flash on or off
// RL4 - host should not change level or edge while the pin drives flash
// RL5 - config holds guard threshold and torch ramp select, ramp default on
// RL6 - config time-out code selects flash duration from 40 ms to 1600 ms
// RL7 - flash current code is seven bits, default zero
// RL8 - torch current code is seven bits, default zero
// RL9 - read-only fault flags: guard, short, thermal, lockout, time-out
// RL10 - writing one to identity bit 7 requests a software reset
// RL11 - identity register returns fixed device and revision fields
// RL12 - software reset restores defaults, clears faults, request self-clears
// RL13 - mode register at 0x01 with default 0x20
// RL14 - register address steps by one after each acked data byte
// RL15 - flash held for the time-out switches source off and flags it
module fled_driver_regs
  import fled_pkg::*;
#(
  parameter int unsigned CYC_PER_MS  = CYC_PER_MS_DFLT,
  parameter logic [2:0]  DEV_ID_CODE = 3'h5, // arbitrary value
  parameter logic [2:0]  REV_CODE    = 3'h2  // arbitrary value
)(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        scl,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOeN,
  input  wire logic        strobe,
  input  wire logic        lowVinHit,
  input  wire logic        ledShort,
  input  wire logic        thermalShutdown,
  input  wire logic        supplyUndervoltageLockout,
  output logic             sourceOn,
  output fled_mode_e       activeMode,
  output logic [6:0]       currentCode,
  output logic             guardEnable,
  output logic [2:0]       guardThreshold
);
  localparam int unsigned RAMP_RAW  = CYC_PER_MS * RAMP_TIME_MS / RAMP_STEPS;
  localparam int unsigned RAMP_STEP = (RAMP_RAW < 1) ? 1 : RAMP_RAW;

  // fault input order: guard, short, thermal, lockout
  typedef struct packed {
    logic [1:0]  strbS;
    logic        strbPrev;
    logic [3:0]  fltS0;
    logic [3:0]  fltS1;
    logic [4:0]  mode;
    logic [7:0]  cfg;
    logic [6:0]  flash;
    logic [6:0]  torch;
    logic [7:0]  fault;
    logic        edgeOn;
    logic        toHit;
    logic [14:0] msDiv;
    logic [10:0] msCnt;
    logic [7:0]  rampDiv;
    logic [6:0]  rampCode;
    logic        srcOn;
    fled_mode_e  actMode;
    logic [6:0]  code;
    logic        swRst;
  } fled_regs_s;

  fled_regs_s q;
  fled_regs_s d;
  fled_reg_if bus ();

  fled_mode_e modeSel;
  logic       pinHi;
  logic       pinRise;
  logic       pinGate;
  logic       rawFlash;
  logic       onReq;
  logic       kill;
  logic       msTick;
  logic       rampTick;

  function automatic logic [10:0] timeoutMs(input logic [3:0] c);
    logic [10:0] ms;
    ms = TO_UNDEF_MS;
    if (c <= TO_SHORT_MAX)
      ms = 11'(({7'h00, c} + 11'h001) * TO_STEP_MS);
    else if (c == TO_800_CODE)
      ms = TO_800_MS;
    else if (c == TO_1000_CODE)
      ms = TO_1000_MS;
    else if (c >= TO_LONG_CODE)
      ms = 11'(TO_LONG_MS + {7'h00, c - TO_LONG_CODE} * TO_LONG_STEP_MS);
    return ms;
  endfunction

  fled_i2c_target u_i2c (
    .clk_sys (clk_sys),
    .rst     (rst),
    .scl     (scl),
    .sdaIn   (sdaIn),
    .sdaOeN  (sdaOeN),
    .bus     (bus.target)
  );

  assign modeSel  = fled_mode_e'(q.mode[1:0]);
  assign pinHi    = q.strbS[1];
  assign pinRise  = pinHi & ~q.strbPrev;
  assign pinGate  = !q.mode[MODE_PIN_EN_BIT] ? 1'b1 :
                    q.mode[MODE_EDGE_BIT] ? q.edgeOn : pinHi; // RL2
  assign rawFlash = modeSel == MODE_FLASH && pinGate;
  assign onReq    = modeSel != MODE_STANDBY && !q.toHit &&
                    (modeSel == MODE_TORCH || pinGate);
  // thermal and lockout cut the source only while present
  assign kill     = q.fltS1[2] | q.fltS1[3];
  assign msTick   = q.msDiv == 15'(CYC_PER_MS - 1);
  assign rampTick = q.rampDiv == 8'(RAMP_STEP - 1);

  always_comb begin
    unique case (bus.regAddr)
      ADDR_MODE:  bus.rdData = {MODE_RST[7:5], q.mode}; // RL1 RL13
      ADDR_CFG:   bus.rdData = q.cfg;
      ADDR_FLASH: bus.rdData = {1'b0, q.flash};
      ADDR_TORCH: bus.rdData = {1'b0, q.torch};
      ADDR_FAULT: bus.rdData = q.fault;
      ADDR_ID:    bus.rdData = {2'h0, DEV_ID_CODE, REV_CODE}; // RL11
      default:    bus.rdData = 8'h00;
    endcase
  end

  always_comb begin
    d          = q;
    d.strbS    = {q.strbS[0], strobe};
    d.strbPrev = q.strbS[1];
    d.fltS0    = {supplyUndervoltageLockout, thermalShutdown,
                  ledShort, lowVinHit};
    d.fltS1    = q.fltS0;
    d.swRst    = 1'b0;
    if (q.swRst) begin
      d.mode   = MODE_RST[4:0]; // RL12
      d.cfg    = CFG_RST;
      d.flash  = FLASH_RST;
      d.torch  = TORCH_RST;
      d.fault  = FAULT_RST;
      d.edgeOn = 1'b0;
      d.toHit  = 1'b0;
    end else if (bus.wrStb) begin
      unique case (bus.regAddr)
        ADDR_MODE:  d.mode  = bus.wrData[4:0]; // RL2
        ADDR_CFG:   d.cfg   = bus.wrData; // RL5
        ADDR_FLASH: d.flash = bus.wrData[6:0]; // RL7
        ADDR_TORCH: d.torch = bus.wrData[6:0]; // RL8
        ADDR_ID:    d.swRst = bus.wrData[ID_SWRST_BIT]; // RL10
        default: ;
      endcase
    end
    // each rising edge flips the flash, so any pulse width works
    // no toggle in a reset cycle, else a stale flash waits for edge mode
    if (q.mode[MODE_EDGE_BIT] && pinRise && !q.swRst)
      d.edgeOn = ~d.edgeOn; // RL3
    if (!rawFlash) begin
      d.toHit = 1'b0;
      d.msCnt = 11'h000;
      d.msDiv = 15'h0000;
    end else if (!q.toHit) begin
      d.msDiv = msTick ? 15'h0000 : q.msDiv + 15'h0001;
      if (msTick) begin
        d.msCnt = q.msCnt + 11'h001;
        if (q.msCnt + 11'h001 == timeoutMs(q.cfg[4:1])) begin // RL6
          d.toHit               = 1'b1; // RL15
          d.fault[FLT_TO_BIT]   = 1'b1;
          d.edgeOn              = 1'b0;
        end
      end
    end
    // flags are sticky; a new event beats a same-cycle reset
    if (q.mode[MODE_GUARD_BIT] && q.fltS1[0])
      d.fault[FLT_GUARD_BIT] = 1'b1; // RL9
    if (q.fltS1[1]) d.fault[FLT_SHORT_BIT] = 1'b1;
    if (q.fltS1[2]) d.fault[FLT_TSD_BIT]   = 1'b1;
    if (q.fltS1[3]) d.fault[FLT_UVL_BIT]   = 1'b1;
    d.srcOn   = onReq && !kill && !q.swRst; // RL15
    d.actMode = d.srcOn ? modeSel : MODE_STANDBY;
    // ramp climbs one code per step over 1 ms, tracks a lowered target
    if (!(q.srcOn && q.actMode == MODE_TORCH)) begin
      d.rampCode = 7'h00;
      d.rampDiv  = 8'h00;
    end else begin
      d.rampDiv = rampTick ? 8'h00 : q.rampDiv + 8'h01;
      if (q.rampCode > q.torch)
        d.rampCode = q.torch;
      else if (rampTick && q.rampCode < q.torch)
        d.rampCode = q.rampCode + 7'h01;
    end
    unique case (modeSel)
      MODE_FLASH: d.code = q.flash; // RL7
      MODE_TORCH: d.code = q.cfg[CFG_RAMP_BIT] ? q.rampCode : q.torch;
      default:    d.code = q.torch; // RL8
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= '{strbS: 2'h0, strbPrev: 1'b0, fltS0: 4'h0, fltS1: 4'h0,
             mode: MODE_RST[4:0], cfg: CFG_RST, flash: FLASH_RST,
             torch: TORCH_RST, fault: FAULT_RST, edgeOn: 1'b0,
             toHit: 1'b0, msDiv: 15'h0000, msCnt: 11'h000,
             rampDiv: 8'h00, rampCode: 7'h00, srcOn: 1'b0,
             actMode: MODE_STANDBY, code: 7'h00, swRst: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign sdaOut         = 1'b0;
  assign sourceOn       = q.srcOn;
  assign activeMode     = q.actMode;
  assign currentCode    = q.code;
  assign guardEnable    = q.mode[MODE_GUARD_BIT];
  assign guardThreshold = q.cfg[7:5];

  property p_mode_rsvd;
    @(posedge clk_sys) disable iff (rst)
    bus.regAddr == ADDR_MODE |-> bus.rdData[7:5] == MODE_RST[7:5];
  endproperty
  a_mode_rsvd: assert property (p_mode_rsvd) // RL1
    else $error("mode reserved bits not fixed");

  property p_mode_wr;
    @(posedge clk_sys) disable iff (rst)
    bus.wrStb && bus.regAddr == ADDR_MODE && !q.swRst
      |=> q.mode == $past(bus.wrData[4:0]);
  endproperty
  a_mode_wr: assert property (p_mode_wr) // RL2
    else $error("mode write not taken");

  property p_level_pin;
    @(posedge clk_sys) disable iff (rst)
    modeSel == MODE_FLASH && q.mode[MODE_PIN_EN_BIT] &&
      !q.mode[MODE_EDGE_BIT] && pinHi && !q.toHit && !kill && !q.swRst
      |=> sourceOn && activeMode == MODE_FLASH;
  endproperty
  a_level_pin: assert property (p_level_pin) // RL2
    else $error("level trigger did not start flash");

  property p_edge_pin;
    @(posedge clk_sys) disable iff (rst)
    q.mode[MODE_EDGE_BIT] && pinRise && !q.swRst
      |=> q.edgeOn != $past(q.edgeOn);
  endproperty
  a_edge_pin: assert property (p_edge_pin) // RL3
    else $error("edge trigger did not toggle");

  property p_cfg_wr;
    @(posedge clk_sys) disable iff (rst)
    bus.wrStb && bus.regAddr == ADDR_CFG && !q.swRst
      |=> guardThreshold == $past(bus.wrData[7:5]);
  endproperty
  a_cfg_wr: assert property (p_cfg_wr) // RL5
    else $error("threshold not updated");

  property p_to_len;
    @(posedge clk_sys) disable iff (rst)
    $rose(q.toHit) |-> $past(q.msCnt) + 11'h001 == timeoutMs(q.cfg[4:1]);
  endproperty
  a_to_len: assert property (p_to_len) // RL6
    else $error("time-out length wrong");

  property p_flash_code;
    @(posedge clk_sys) disable iff (rst)
    modeSel == MODE_FLASH |=> currentCode == $past(q.flash);
  endproperty
  a_flash_code: assert property (p_flash_code) // RL7
    else $error("flash code not applied");

  property p_torch_code;
    @(posedge clk_sys) disable iff (rst)
    modeSel == MODE_TORCH && !q.cfg[CFG_RAMP_BIT]
      |=> currentCode == $past(q.torch);
  endproperty
  a_torch_code: assert property (p_torch_code) // RL8
    else $error("torch code not applied");

  property p_fault_ro;
    @(posedge clk_sys) disable iff (rst)
    bus.wrStb && bus.regAddr == ADDR_FAULT && !q.swRst
      |=> ($past(q.fault) & ~q.fault) == 8'h00;
  endproperty
  a_fault_ro: assert property (p_fault_ro) // RL9
    else $error("fault flag cleared by write");

  property p_swrst_req;
    @(posedge clk_sys) disable iff (rst)
    bus.wrStb && bus.regAddr == ADDR_ID && !q.swRst
      |=> q.swRst == $past(bus.wrData[ID_SWRST_BIT]);
  endproperty
  a_swrst_req: assert property (p_swrst_req) // RL10
    else $error("reset request mismatch");

  property p_id_read;
    @(posedge clk_sys) disable iff (rst)
    bus.regAddr == ADDR_ID
      |-> bus.rdData == {2'h0, DEV_ID_CODE, REV_CODE};
  endproperty
  a_id_read: assert property (p_id_read) // RL11
    else $error("identity read wrong");

  property p_swrst;
    @(posedge clk_sys) disable iff (rst)
    q.swRst |=> q.mode == MODE_RST[4:0] && q.cfg == CFG_RST &&
      q.flash == FLASH_RST && q.torch == TORCH_RST && !q.swRst;
  endproperty
  a_swrst: assert property (p_swrst) // RL12
    else $error("software reset incomplete");

  property p_timeout;
    @(posedge clk_sys) disable iff (rst)
    $rose(q.toHit) |-> q.fault[FLT_TO_BIT] ##1 !sourceOn;
  endproperty
  a_timeout: assert property (p_timeout) // RL15
    else $error("time-out did not stop source");

  c_timeout: cover property (@(posedge clk_sys) disable iff (rst)
    $rose(q.toHit));
  c_swrst: cover property (@(posedge clk_sys) disable iff (rst)
    q.swRst);
  c_ramp: cover property (@(posedge clk_sys) disable iff (rst)
    q.actMode == MODE_TORCH && q.torch != 7'h00 && q.rampCode == q.torch);
endmodule

// File: testbench/fled_i2c_master.sv
module fled_i2c_master #(
  parameter int Q = 6
)(
  input  wire logic clk_sys,
  input  wire logic sdaLine,
  output logic      scl,
  output logic      sdaDrvN
);
  timeunit 1ns;
  timeprecision 100ps;

  // released lines idle high through the pull-up
  initial begin
    scl     = 1'b1;
    sdaDrvN = 1'b1;
  end

  // each phase lasts Q clocks, well above the 4-clock minimum
  task automatic hold();
    repeat (Q) @(posedge clk_sys);
    #1;
  endtask

  // serves as repeated start as well
  task automatic start();
    sdaDrvN = 1'b1;
    hold();
    scl = 1'b1;
    hold();
    sdaDrvN = 1'b0;
    hold();
    scl = 1'b0;
    hold();
  endtask

  task automatic stop();
    sdaDrvN = 1'b0;
    hold();
    scl = 1'b1;
    hold();
    sdaDrvN = 1'b1;
    hold();
  endtask

  // data changes only while scl is low, sampled mid-high
  task automatic bitIo(input logic bOut, output logic bIn);
    sdaDrvN = bOut;
    hold();
    scl = 1'b1;
    hold();
    bIn = sdaLine;
    hold();
    scl = 1'b0;
    hold();
  endtask

  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bitIo(d[i], b);
    end
    bitIo(1'b1, b);
    ack = ~b;
  endtask

  // ackIt low ends a read burst
  task automatic recvByte(output logic [7:0] d, input logic ackIt);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bitIo(1'b1, d[i]);
    end
    bitIo(~ackIt, b);
  endtask
endmodule

// File: testbench/test_fled_driver_regs.sv
module test_fled_driver_regs import fled_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [2:0] DEV_ID = 3'h3; // arbitrary value
  localparam logic [2:0] REV    = 3'h6; // arbitrary value
  localparam logic [7:0] ID_EXP = {2'h0, DEV_ID, REV};

  logic       clk_sys;
  logic       rst;
  logic       scl;
  logic       sdaDrvN;
  logic       sdaOeN;
  logic       sdaOut;
  wire logic  sdaLine;
  logic       strobe;
  logic       lowVinHit;
  logic       ledShort;
  logic       thermalShutdown;
  logic       supplyUndervoltageLockout;
  logic       sourceOn;
  fled_mode_e activeMode;
  logic [6:0] currentCode;
  logic       guardEnable;
  logic [2:0] guardThreshold;
  int         err_count;
  int         checked;
  logic       ack;
  logic [7:0] mTab [3];
  logic [1:0] aTab [3];

  // open-drain bus with pull-up
  assign sdaLine = sdaDrvN & (sdaOeN | sdaOut);

  fled_driver_regs #(
    .CYC_PER_MS  (40),
    .DEV_ID_CODE (DEV_ID),
    .REV_CODE    (REV)
  ) i_fled_driver_regs (
    .clk_sys                   (clk_sys),
    .rst                       (rst),
    .scl                       (scl),
    .sdaIn                     (sdaLine),
    .sdaOut                    (sdaOut),
    .sdaOeN                    (sdaOeN),
    .strobe                    (strobe),
    .lowVinHit                 (lowVinHit),
    .ledShort                  (ledShort),
    .thermalShutdown           (thermalShutdown),
    .supplyUndervoltageLockout (supplyUndervoltageLockout),
    .sourceOn                  (sourceOn),
    .activeMode                (activeMode),
    .currentCode               (currentCode),
    .guardEnable               (guardEnable),
    .guardThreshold            (guardThreshold)
  );

  fled_i2c_master i_fled_i2c_master (
    .clk_sys (clk_sys),
    .sdaLine (sdaLine),
    .scl     (scl),
    .sdaDrvN (sdaDrvN)
  );

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chkReg(input logic [7:0] a, input logic [7:0] e,
                        input logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] reg %h expected %h seen %h", a, e, g);
    end
  endtask

  task automatic chkPin(input string n, input logic [7:0] e,
                        input logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wrRegs(input logic [7:0] a, input logic [7:0] d[$]);
    i_fled_i2c_master.start();
    i_fled_i2c_master.sendByte({I2C_DEV_ADDR, 1'b0}, ack);
    chkPin("addrAck", 8'h01, {7'h0, ack});
    i_fled_i2c_master.sendByte(a, ack);
    chkPin("regAck", 8'h01, {7'h0, ack});
    foreach (d[i]) begin
      i_fled_i2c_master.sendByte(d[i], ack);
      chkPin("dataAck", 8'h01, {7'h0, ack});
    end
    i_fled_i2c_master.stop();
  endtask

  // reads exp.size() bytes from a onwards in one burst
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp[$]);
    logic [7:0] b;
    i_fled_i2c_master.start();
    i_fled_i2c_master.sendByte({I2C_DEV_ADDR, 1'b0}, ack);
    i_fled_i2c_master.sendByte(a, ack);
    i_fled_i2c_master.start();
    i_fled_i2c_master.sendByte({I2C_DEV_ADDR, 1'b1}, ack);
    chkPin("rdAddrAck", 8'h01, {7'h0, ack});
    foreach (exp[i]) begin
      i_fled_i2c_master.recvByte(b, i < exp.size() - 1);
      chkReg(a + 8'(i), exp[i], b);
    end
    i_fled_i2c_master.stop();
  endtask

  task automatic pulse();
    strobe = 1'b1;
    cyc(1);
    strobe = 1'b0;
    cyc(10);
  endtask

  task automatic chkOut(input logic [1:0] m, input logic on);
    chkPin("activeMode", {6'h0, m}, {6'h0, activeMode});
    chkPin("sourceOn", {7'h0, on}, {7'h0, sourceOn});
  endtask

  initial begin
    repeat (100000) @(posedge clk_sys);
    err_count++;
    give_verdict();
  end

  initial begin
    rst = 1'b1;
    strobe = 1'b0;
    lowVinHit = 1'b0;
    ledShort = 1'b0;
    thermalShutdown = 1'b0;
    supplyUndervoltageLockout = 1'b0;
    mTab = '{8'h02, 8'h05, 8'h10};
    aTab = '{2'h2, 2'h1, 2'h0};
    cyc(3);
    rst = 1'b0;
    cyc(4);
    rdChk(ADDR_MODE, '{MODE_RST, CFG_RST, 8'h00, 8'h00, FAULT_RST,
                       ID_EXP});
    chkOut(2'h0, 1'b0);
    // foreign device address must not be acknowledged
    i_fled_i2c_master.start();
    i_fled_i2c_master.sendByte({7'h65, 1'b0}, ack);
    chkPin("foreignAck", 8'h00, {7'h0, ack});
    i_fled_i2c_master.stop();
    // reserved bits set on purpose; fault register is read-only
    wrRegs(ADDR_FLASH, '{8'hff, 8'h80, 8'hff});
    wrRegs(ADDR_MODE, '{8'he0});
    rdChk(ADDR_MODE,
          '{8'h20, CFG_RST, 8'h7f, 8'h00, 8'h00});
    wrRegs(ADDR_CFG, '{8'ha1, 8'h7f, 8'h55});
    chkPin("guardThreshold", 8'h05, {5'h0, guardThreshold});
    strobe = 1'b1;
    for (int i = 0; i < 3; i++) begin
      wrRegs(ADDR_MODE, '{mTab[i]});
      cyc(200);
      chkOut(aTab[i], aTab[i] != 2'h0);
      if (aTab[i] != 2'h0) begin
        chkPin("currentCode", 8'h55, {1'b0, currentCode});
      end
    end
    chkPin("guardEnable", 8'h01, {7'h0, guardEnable});
    strobe = 1'b0;
    // ramp off: torch code must apply at once
    wrRegs(ADDR_CFG, '{8'ha0});
    wrRegs(ADDR_MODE, '{8'h02});
    cyc(4);
    chkPin("currentCode", 8'h55, {1'b0, currentCode});
    // flash without the pin runs into the 40 ms time-out
    wrRegs(ADDR_MODE, '{8'h03});
    cyc(4);
    chkOut(2'h3, 1'b1);
    chkPin("currentCode", 8'h7f, {1'b0, currentCode});
    cyc(1400);
    chkOut(2'h3, 1'b1);
    cyc(300);
    chkPin("sourceOn", 8'h00, {7'h0, sourceOn});
    rdChk(ADDR_FAULT, '{8'h01});
    // level trigger
    wrRegs(ADDR_MODE, '{8'h07});
    cyc(10);
    chkOut(2'h0, 1'b0);
    strobe = 1'b1;
    cyc(10);
    chkOut(2'h3, 1'b1);
    strobe = 1'b0;
    cyc(10);
    chkOut(2'h0, 1'b0);
    // selection changed only while the pin is idle
    wrRegs(ADDR_MODE, '{8'h0f});
    pulse();
    chkOut(2'h3, 1'b1);
    pulse();
    chkOut(2'h0, 1'b0);
    // sticky fault flags
    wrRegs(ADDR_MODE, '{8'h10});
    lowVinHit = 1'b1;
    ledShort = 1'b1;
    thermalShutdown = 1'b1;
    supplyUndervoltageLockout = 1'b1;
    cyc(5);
    lowVinHit = 1'b0;
    ledShort = 1'b0;
    thermalShutdown = 1'b0;
    supplyUndervoltageLockout = 1'b0;
    cyc(5);
    rdChk(ADDR_FAULT, '{8'h67});
    // software reset restores every default
    wrRegs(ADDR_ID, '{8'h80});
    cyc(4);
    rdChk(ADDR_MODE, '{MODE_RST, CFG_RST, 8'h00, 8'h00, 8'h00,
                       ID_EXP});
    chkPin("guardEnable", 8'h00, {7'h0, guardEnable});
    chkPin("guardThreshold", 8'h00, {5'h0, guardThreshold});
    give_verdict();
  end
endmodule
